// ---- rtl/dasc_defines.svh ----
// widths, masks and counts shared by the converter control block
`ifndef DASC_DEFINES_SVH
`define DASC_DEFINES_SVH
`define DASC_RES_W      10
`define DASC_FAST_LSB   4'h2
`define DASC_MSB        4'h9
`define DASC_DATA_W     14
`define DASC_CH_W       4
`define DASC_EXT_W      2
`define DASC_NCH        16
`define DASC_CHMASK0    16'hFFFF
`define DASC_CHMASK1    16'h00FF
`define DASC_SHARED     4'h4
`define DASC_NRES       8
`define DASC_RIDX_W     3
`define DASC_QDEPTH     4
`define DASC_QPTR_W     2
`define DASC_QCNT_W     3
`define DASC_QFULL      3'h4
`define DASC_STC_W      8
`define DASC_CTC_W      4
`define DASC_ACC_W      4
`define DASC_NTRIG      8
`define DASC_TSEL_W     3
`define DASC_PRIO_W     2
`define DASC_NPIN       24
`define DASC_TRIAL_MSB  10'h200
`endif

// ---- rtl/dasc_pkg.sv ----
// types shared by the converter control block
`include "dasc_defines.svh"
package dasc_pkg;
   typedef enum logic [1:0] {RED_NONE, RED_LIMIT, RED_ACCUM} dasc_reduce_t;
   typedef enum logic [1:0] {SRC_NONE, SRC_PAR, SRC_QUE, SRC_INS} dasc_src_t;
   typedef enum logic [1:0] {SAR_IDLE, SAR_WAKE, SAR_SAMPLE, SAR_CONV} dasc_sar_st_t;

   typedef struct packed {
      logic [`DASC_EXT_W-1:0] ext;
      logic [`DASC_CH_W-1:0]  chan;
   } dasc_req_t;

   typedef struct packed {
      logic [`DASC_DATA_W-1:0] data;
      logic [`DASC_CH_W-1:0]   chan;
   } dasc_res_t;

   typedef struct packed {
      dasc_sar_st_t           st;
      logic [`DASC_STC_W-1:0] cnt;
      logic [`DASC_CTC_W-1:0] div;
      logic [3:0]             bitn;
      logic [`DASC_RES_W-1:0] sar;
      logic [`DASC_RES_W-1:0] result;
      logic                   done;
   } dasc_sar_s_t;

   typedef struct packed {
      logic [`DASC_NCH-1:0]                par_pend;
      dasc_req_t [`DASC_QDEPTH-1:0]        q;
      logic [`DASC_QPTR_W-1:0]             q_rd;
      logic [`DASC_QPTR_W-1:0]             q_wr;
      logic [`DASC_QCNT_W-1:0]             q_cnt;
      logic                                q_run;
      logic                                ins_pend;
      dasc_req_t                           ins;
      dasc_req_t                           cur;
      dasc_src_t                           src;
      logic [`DASC_RIDX_W-1:0]             tgt;
      logic                                busy;
      logic                                start;
      logic                                wake;
      logic                                pd;
      dasc_res_t [`DASC_NRES-1:0]          res;
      logic [`DASC_NRES-1:0]               rvalid;
      logic [`DASC_RIDX_W-1:0]             wr_ptr;
      logic [`DASC_DATA_W-1:0]             acc;
      logic [`DASC_ACC_W-1:0]              acc_n;
      logic [2:0]                          trig_prev;
      logic                                xfer_req;
      logic [`DASC_RIDX_W-1:0]             xfer_idx;
      logic                                srv_req;
      dasc_res_t                           rd_data;
   } dasc_cv_t;

   typedef struct packed {
      dasc_cv_t [1:0]        cv;
      logic [`DASC_NPIN-1:0] port_in;
   } dasc_top_t;
endpackage

// ---- rtl/dasc_sar.sv ----
// successive approximation engine: sample phase, then one bit per divided clock
`timescale 1ns/1ns
`default_nettype none
`include "dasc_defines.svh"
module dasc_sar
(
   // clock and reset
   input  wire logic                   i_ref_clk,
   input  wire logic                   i_rstn,
   // control
   input  wire logic                   i_start,
   input  wire logic                   i_wake,
   input  wire logic                   i_fast,
   input  wire logic [`DASC_STC_W-1:0] i_stc,
   input  wire logic [`DASC_CTC_W-1:0] i_ctc,
   input  wire logic                   i_bwd,
   input  wire logic                   i_mux_test,
   // analog comparator
   input  wire logic                   i_cmp,
   // outputs
   output logic [`DASC_RES_W-1:0]      o_dac,
   output logic [`DASC_RES_W-1:0]      o_result,
   output logic                        o_done,
   output logic                        o_sample,
   output logic                        o_pre,
   output logic                        o_mtest
);
   dasc_pkg::dasc_sar_s_t s;
   dasc_pkg::dasc_sar_s_t n;
   logic                  tick;
   logic [3:0]            lsb;

   always_comb
   begin
      n      = s;
      n.done = 1'b0;
      tick   = (s.div == '0);
      lsb    = i_fast ? `DASC_FAST_LSB : 4'h0;
      case (s.st)
         dasc_pkg::SAR_IDLE:
         begin
            if (i_start)
            begin
               // leaving power-down costs one settling cycle
               n.st  = i_wake ? dasc_pkg::SAR_WAKE : dasc_pkg::SAR_SAMPLE;
               n.cnt = i_stc;
               n.sar = '0;
            end
         end
         dasc_pkg::SAR_WAKE:
            n.st = dasc_pkg::SAR_SAMPLE;
         dasc_pkg::SAR_SAMPLE:
         begin
            if (s.cnt == '0)
            begin
               n.st   = dasc_pkg::SAR_CONV;
               n.bitn = `DASC_MSB;
               n.sar  = `DASC_TRIAL_MSB;
               n.div  = i_ctc;
            end
            else
               n.cnt = s.cnt - 8'h01;
         end
         dasc_pkg::SAR_CONV:
         begin
            n.div = tick ? i_ctc : s.div - 4'h1;
            if (tick)
            begin
               n.sar[s.bitn] = i_cmp;
               if (s.bitn == lsb)
               begin
                  n.st     = dasc_pkg::SAR_IDLE;
                  n.done   = 1'b1;
                  // fast mode keeps the eight upper decisions
                  n.result = i_fast ? {2'h0, n.sar[9:2]} : n.sar;
               end
               else
               begin
                  n.bitn            = s.bitn - 4'h1;
                  n.sar[s.bitn-4'h1] = 1'b1;
               end
            end
         end
         default:
            n.st = dasc_pkg::SAR_IDLE;
      endcase
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rstn)
         s <= '0;
      else
         s <= n;
   end

   assign o_dac    = s.sar;
   assign o_result = s.result;
   assign o_done   = s.done;
   assign o_sample = (s.st == dasc_pkg::SAR_SAMPLE);
   // precharge only in the first sample cycle so an open input drifts visibly
   assign o_pre    = i_bwd & o_sample & (s.cnt == i_stc);
   assign o_mtest  = i_mux_test & o_sample;

   sequence fast_conv_s;
      (s.st == dasc_pkg::SAR_CONV)[*8] ##1 o_done;
   endsequence

   done_pulse_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      o_done |=> !o_done)
      else $error("done lasted more than one cycle");
   msb_first_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      (o_sample && s.cnt == '0) |=> (s.sar == `DASC_TRIAL_MSB && s.bitn == `DASC_MSB))
      else $error("conversion did not start at the top bit");
   fast_len_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      (o_sample && s.cnt == '0 && i_fast && i_ctc == '0) |=> fast_conv_s)
      else $error("fast conversion did not take eight steps");
   sample_go_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      (s.st == dasc_pkg::SAR_IDLE && i_start && !i_wake) |=> o_sample && s.cnt == $past(i_stc))
      else $error("sample phase not loaded from the sample time");
endmodule
`default_nettype wire

// ---- rtl/dasc_top.sv ----
// request sources, arbitration, result store and pins for two converters
`timescale 1ns/1ns
`default_nettype none
`include "dasc_defines.svh"
module dasc_top
(
   // clock and reset
   input  wire logic                                    i_ref_clk,
   input  wire logic                                    i_rstn,
   // configuration
   input  wire logic                                    i_sync,
   input  wire logic [1:0]                              i_fast,
   input  wire logic [1:0][`DASC_STC_W-1:0]             i_stc,
   input  wire logic [1:0][`DASC_CTC_W-1:0]             i_ctc,
   input  wire logic [1:0]                              i_apd,
   input  wire logic [1:0]                              i_fifo_en,
   input  wire logic [1:0][`DASC_NRES-1:0]              i_wfr,
   input  wire dasc_pkg::dasc_reduce_t [1:0]            i_reduce,
   input  wire logic [1:0][`DASC_RES_W-1:0]             i_lim_lo,
   input  wire logic [1:0][`DASC_RES_W-1:0]             i_lim_hi,
   input  wire logic [1:0][`DASC_ACC_W-1:0]             i_acc_cnt,
   input  wire logic [1:0][1:0]                         i_irq_en,
   input  wire logic [1:0]                              i_xfer_en,
   input  wire logic [1:0][2:0][`DASC_PRIO_W-1:0]       i_prio,
   input  wire logic [1:0][2:0][`DASC_TSEL_W-1:0]       i_trig_sel,
   input  wire logic [1:0][`DASC_NCH-1:0]               i_bwd,
   input  wire logic [1:0]                              i_mux_test,
   // requests
   input  wire logic [`DASC_NTRIG-1:0]                  i_trig,
   input  wire logic [1:0][2:0]                         i_sw_start,
   input  wire logic [1:0][`DASC_NCH-1:0]               i_par_mask,
   input  wire logic [1:0][`DASC_EXT_W-1:0]             i_par_ext,
   input  wire logic [1:0]                              i_q_push,
   input  wire dasc_pkg::dasc_req_t [1:0]               i_q_req,
   input  wire dasc_pkg::dasc_req_t [1:0]               i_ins_req,
   // result access
   input  wire logic [1:0]                              i_rd,
   input  wire logic [1:0][`DASC_RIDX_W-1:0]            i_rd_idx,
   input  wire logic [1:0]                              i_xfer_ack,
   // analog side
   input  wire logic [1:0]                              i_cmp,
   input  wire logic [`DASC_NPIN-1:0]                   i_pin,
   input  wire logic [`DASC_NPIN-1:0]                   i_dig_dis,
   // converter outputs
   output logic [1:0][`DASC_RES_W-1:0]                  o_dac,
   output logic [1:0][`DASC_CH_W-1:0]                   o_chan,
   output logic [1:0][`DASC_EXT_W-1:0]                  o_ext_mux,
   output logic [1:0]                                   o_shared,
   output logic [1:0]                                   o_sample,
   output logic [1:0]                                   o_pre,
   output logic [1:0]                                   o_mtest,
   output logic [1:0]                                   o_pd,
   output logic [1:0]                                   o_busy,
   output logic [1:0]                                   o_q_full,
   // results and events
   output dasc_pkg::dasc_res_t [1:0]                    o_rd_data,
   output logic [1:0][`DASC_NRES-1:0]                   o_rvalid,
   output logic [1:0]                                   o_xfer_req,
   output logic [1:0][`DASC_RIDX_W-1:0]                 o_xfer_idx,
   output dasc_pkg::dasc_res_t [1:0]                    o_xfer_data,
   output logic [1:0]                                   o_srv_req,
   // digital port readback
   output logic [`DASC_NPIN-1:0]                        o_port_in
);
   localparam logic [1:0][`DASC_NCH-1:0] CHM = {`DASC_CHMASK1, `DASC_CHMASK0};

   dasc_pkg::dasc_top_t           s;
   dasc_pkg::dasc_top_t           n;
   logic [1:0]                    sar_done;
   logic [1:0][`DASC_RES_W-1:0]   sar_res;

   always_comb
   begin
      logic [2:0]              trg [2];
      logic                    rdy [2];
      dasc_pkg::dasc_src_t     best [2];
      dasc_pkg::dasc_req_t     req [2];
      logic [`DASC_RIDX_W-1:0] tgt [2];
      logic [`DASC_PRIO_W-1:0] bp;
      logic [`DASC_DATA_W-1:0] r;
      logic                    keep;
      logic                    lim;
      bp   = '0;
      r    = '0;
      keep = 1'b0;
      lim  = 1'b0;
      n    = s;
      n.port_in = i_pin & ~i_dig_dis;
      for (int g = 0; g < 2; g++)
      begin
         trg[g]  = '0;
         best[g] = dasc_pkg::SRC_NONE;
         req[g]  = '0;
         for (int k = 0; k < 3; k++)
            trg[g][k] = (i_trig[i_trig_sel[g][k]] & ~s.cv[g].trig_prev[k])
                        | i_sw_start[g][k];
         if (|s.cv[g].par_pend)
         begin
            best[g] = dasc_pkg::SRC_PAR;
            bp      = i_prio[g][0];
            for (int c = `DASC_NCH - 1; c >= 0; c--)
               if (s.cv[g].par_pend[c])
                  req[g].chan = 4'(c);
            req[g].ext = i_par_ext[g];
         end
         // on equal priority later sources win: insert over queue over parallel
         if (s.cv[g].q_run && s.cv[g].q_cnt != '0 &&
             (best[g] == dasc_pkg::SRC_NONE || i_prio[g][1] >= bp))
         begin
            best[g] = dasc_pkg::SRC_QUE;
            bp      = i_prio[g][1];
            req[g]  = s.cv[g].q[s.cv[g].q_rd];
         end
         if (s.cv[g].ins_pend &&
             (best[g] == dasc_pkg::SRC_NONE || i_prio[g][2] >= bp))
         begin
            best[g] = dasc_pkg::SRC_INS;
            req[g]  = s.cv[g].ins;
         end
         tgt[g] = i_fifo_en[g] ? s.cv[g].wr_ptr : req[g].chan[`DASC_RIDX_W-1:0];
         rdy[g] = (best[g] != dasc_pkg::SRC_NONE) && !s.cv[g].busy &&
                  !(s.cv[g].rvalid[tgt[g]] && i_wfr[g][tgt[g]]);
      end

      for (int g = 0; g < 2; g++)
      begin
         n.cv[g].start    = 1'b0;
         n.cv[g].xfer_req = 1'b0;
         n.cv[g].srv_req  = 1'b0;
         for (int k = 0; k < 3; k++)
            n.cv[g].trig_prev[k] = i_trig[i_trig_sel[g][k]];
         if (trg[g][0])
            n.cv[g].par_pend = s.cv[g].par_pend | (i_par_mask[g] & CHM[g]);
         if (trg[g][1])
            n.cv[g].q_run = 1'b1;
         if (trg[g][2])
         begin
            n.cv[g].ins_pend = 1'b1;
            n.cv[g].ins      = i_ins_req[g];
         end
         if (i_q_push[g] && s.cv[g].q_cnt != `DASC_QFULL)
         begin
            n.cv[g].q[s.cv[g].q_wr] = i_q_req[g];
            n.cv[g].q_wr            = s.cv[g].q_wr + 2'h1;
            n.cv[g].q_cnt           = s.cv[g].q_cnt + 3'h1;
         end
         if (i_rd[g])
         begin
            n.cv[g].rd_data            = s.cv[g].res[i_rd_idx[g]];
            n.cv[g].rvalid[i_rd_idx[g]] = 1'b0;
         end
         if (i_xfer_ack[g])
            n.cv[g].rvalid[s.cv[g].xfer_idx] = 1'b0;

         // sync mode holds a ready converter until its partner is ready too
         if (rdy[g] && (!i_sync || rdy[1-g]))
         begin
            n.cv[g].busy  = 1'b1;
            n.cv[g].start = 1'b1;
            n.cv[g].wake  = s.cv[g].pd;
            n.cv[g].cur   = req[g];
            n.cv[g].src   = best[g];
            n.cv[g].tgt   = tgt[g];
         end

         if (sar_done[g])
         begin
            n.cv[g].busy = 1'b0;
            // entries leave their source only once converted
            case (s.cv[g].src)
               dasc_pkg::SRC_PAR:
                  n.cv[g].par_pend[s.cv[g].cur.chan] = 1'b0;
               dasc_pkg::SRC_QUE:
               begin
                  n.cv[g].q_rd  = s.cv[g].q_rd + 2'h1;
                  n.cv[g].q_cnt = n.cv[g].q_cnt - 3'h1;
                  if (n.cv[g].q_cnt == '0 && !trg[g][1])
                     n.cv[g].q_run = 1'b0;
               end
               // a fresh insert trigger in the finishing cycle must not be lost
               dasc_pkg::SRC_INS:
                  n.cv[g].ins_pend = trg[g][2];
               default:
                  n.cv[g].busy = 1'b0;
            endcase
            r   = `DASC_DATA_W'(sar_res[g]);
            lim = (sar_res[g] < i_lim_lo[g]) || (sar_res[g] > i_lim_hi[g]);
            case (i_reduce[g])
               dasc_pkg::RED_LIMIT:
                  keep = lim;
               dasc_pkg::RED_ACCUM:
               begin
                  r    = s.cv[g].acc + r;
                  keep = (s.cv[g].acc_n + 4'h1 >= i_acc_cnt[g]);
                  n.cv[g].acc   = keep ? '0 : r;
                  n.cv[g].acc_n = keep ? '0 : s.cv[g].acc_n + 4'h1;
               end
               default:
                  keep = 1'b1;
            endcase
            if (keep)
            begin
               // a new result beats a same-cycle read of that register
               n.cv[g].res[s.cv[g].tgt].data = r;
               n.cv[g].res[s.cv[g].tgt].chan = s.cv[g].cur.chan;
               n.cv[g].rvalid[s.cv[g].tgt]   = 1'b1;
               if (i_fifo_en[g])
                  n.cv[g].wr_ptr = s.cv[g].wr_ptr + 3'h1;
               n.cv[g].xfer_req = i_xfer_en[g];
               n.cv[g].xfer_idx = s.cv[g].tgt;
            end
            n.cv[g].srv_req = (i_irq_en[g][0] & keep) |
                              (i_irq_en[g][1] & lim & (i_reduce[g] == dasc_pkg::RED_LIMIT));
         end
         n.cv[g].pd = i_apd[g] && !n.cv[g].busy && (best[g] == dasc_pkg::SRC_NONE) &&
                      !n.cv[g].start;
      end
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rstn)
         s <= '0;
      else
         s <= n;
   end

   for (genvar g = 0; g < 2; g++)
   begin : g_cv
      dasc_sar u_sar
      (
         .i_ref_clk  (i_ref_clk),
         .i_rstn     (i_rstn),
         .i_start    (s.cv[g].start),
         .i_wake     (s.cv[g].wake),
         .i_fast     (i_fast[g]),
         .i_stc      (i_stc[g]),
         .i_ctc      (i_ctc[g]),
         .i_bwd      (i_bwd[g][s.cv[g].cur.chan]),
         .i_mux_test (i_mux_test[g]),
         .i_cmp      (i_cmp[g]),
         .o_dac      (o_dac[g]),
         .o_result   (sar_res[g]),
         .o_done     (sar_done[g]),
         .o_sample   (o_sample[g]),
         .o_pre      (o_pre[g]),
         .o_mtest    (o_mtest[g])
      );
      assign o_chan[g]      = s.cv[g].cur.chan;
      assign o_ext_mux[g]   = s.cv[g].cur.ext;
      assign o_shared[g]    = s.cv[g].busy && (s.cv[g].cur.chan < `DASC_SHARED);
      assign o_pd[g]        = s.cv[g].pd;
      assign o_busy[g]      = s.cv[g].busy;
      assign o_q_full[g]    = (s.cv[g].q_cnt == `DASC_QFULL);
      assign o_rd_data[g]   = s.cv[g].rd_data;
      assign o_rvalid[g]    = s.cv[g].rvalid;
      assign o_xfer_req[g]  = s.cv[g].xfer_req;
      assign o_xfer_idx[g]  = s.cv[g].xfer_idx;
      assign o_xfer_data[g] = s.cv[g].res[s.cv[g].xfer_idx];
      assign o_srv_req[g]   = s.cv[g].srv_req;
   end
   assign o_port_in = s.port_in;

   wfr_hold_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      s.cv[0].start |->
      ((($past(s.cv[0].rvalid) & $past(i_wfr[0])) >> s.cv[0].tgt) & 8'h01) == 8'h00)
      else $error("conversion started over an unread protected result");
   wfr_back_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      s.cv[1].start |->
      ((($past(s.cv[1].rvalid) & $past(i_wfr[1])) >> s.cv[1].tgt) & 8'h01) == 8'h00)
      else $error("second converter overwrote a protected result");
   sync_back_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      (i_sync && $past(i_sync) && s.cv[1].start) |-> s.cv[0].start)
      else $error("second converter started alone in sync mode");
   ins_prio_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      (s.cv[0].start && $past(s.cv[0].ins_pend) && $past(i_prio[0][2]) >= $past(i_prio[0][1])
       && $past(i_prio[0][2]) >= $past(i_prio[0][0])) |-> s.cv[0].src == dasc_pkg::SRC_INS)
      else $error("insert lost arbitration at top priority");
   q_order_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      (s.cv[1].start && s.cv[1].src == dasc_pkg::SRC_QUE) |->
      s.cv[1].cur == $past(s.cv[1].q[s.cv[1].q_rd]))
      else $error("queue entry taken out of order");
   sync_start_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      (i_sync && $past(i_sync) && s.cv[0].start) |-> s.cv[1].start)
      else $error("synchronized converters started apart");
   par_order_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      (s.cv[0].start && s.cv[0].src == dasc_pkg::SRC_PAR) |->
      (($past(s.cv[0].par_pend) & ((16'h0001 << s.cv[0].cur.chan) - 16'h0001)) == '0))
      else $error("parallel request skipped a lower channel");
   xfer_req_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      (sar_done[0] && i_reduce[0] == dasc_pkg::RED_NONE && i_xfer_en[0]) |=>
      (o_xfer_req[0] && o_rvalid[0][o_xfer_idx[0]]))
      else $error("stored result raised no transfer request");
   pd_idle_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      o_pd[0] |-> !o_busy[0] && !o_sample[0])
      else $error("powered down during a conversion");
   busy_done_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      sar_done[0] |=> !o_busy[0])
      else $error("converter stayed busy after its result");
   fifo_step_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      (sar_done[0] && i_fifo_en[0] && i_reduce[0] == dasc_pkg::RED_NONE) |=>
      s.cv[0].wr_ptr == $past(s.cv[0].wr_ptr) + 3'h1)
      else $error("result pointer did not advance");
   port_in_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      $past(i_rstn) |-> o_port_in == $past(i_pin & ~i_dig_dis))
      else $error("port readback does not follow the pins");
   wake_step_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      (s.cv[0].start && s.cv[0].wake) |=> !o_sample[0] ##1 o_sample[0])
      else $error("wake-up did not take one settling cycle");
   xfer_pulse_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      o_xfer_req[0] |=> !o_xfer_req[0])
      else $error("transfer request lasted more than one cycle");
   pre_once_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      o_pre[0] |=> !o_pre[0])
      else $error("precharge lasted more than one cycle");
   mtest_gate_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      o_mtest[1] |-> o_sample[1])
      else $error("multiplexer test strobe outside sampling");
   shared_pin_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      o_shared[1] |-> o_busy[1] && o_chan[1] < `DASC_SHARED)
      else $error("shared pin used for a private channel");
   q_bound_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      s.cv[1].q_cnt <= `DASC_QFULL)
      else $error("queue count beyond its depth");
endmodule
`default_nettype wire

// ---- verification/dasc_analog_src.sv ----
// analog source model: comparator of each source level against the trial code
`timescale 1ns/1ns
`default_nettype none
`include "dasc_defines.svh"
module dasc_analog_src
(
   // trial codes and source levels
   input  wire logic [1:0][`DASC_RES_W-1:0] i_dac,
   input  wire logic [1:0][`DASC_RES_W-1:0] i_level,
   // comparator decisions
   output logic [1:0]                       o_cmp
);
   // a level is held steady by the bench while its converter is busy
   assign o_cmp[0] = i_level[0] >= i_dac[0];
   assign o_cmp[1] = i_level[1] >= i_dac[1];
endmodule
`default_nettype wire

// ---- verification/dual_adc_sequencer_control_bench.sv ----
// self-checking bench: conversions compared with a queue-based model
`timescale 1ns/1ns
`default_nettype none
`include "dasc_defines.svh"
module dual_adc_sequencer_control_bench;
   logic                           i_ref_clk, i_rstn, i_sync;
   logic [1:0]                     i_fast, i_apd, i_fifo_en, i_mux_test, i_q_push, i_rd;
   logic [1:0]                     i_xfer_en, i_xfer_ack, i_cmp, o_pd, o_busy;
   logic [1:0][7:0]                i_stc, i_wfr;
   logic [1:0][3:0]                i_ctc, i_acc_cnt;
   dasc_pkg::dasc_reduce_t [1:0]   i_reduce;
   logic [1:0][9:0]                i_lim_lo, i_lim_hi, lvl;
   logic [1:0][1:0]                i_irq_en, i_par_ext, o_ext_mux;
   logic [1:0][2:0][1:0]           i_prio;
   logic [1:0][2:0][2:0]           i_trig_sel;
   logic [1:0][15:0]               i_bwd, i_par_mask;
   logic [7:0]                     i_trig;
   logic [1:0][2:0]                i_sw_start, i_rd_idx;
   dasc_pkg::dasc_req_t [1:0]      i_q_req, i_ins_req;
   logic [23:0]                    i_pin, i_dig_dis, o_port_in;
   logic [1:0][9:0]                o_dac;
   dasc_pkg::dasc_res_t [1:0]      o_rd_data, o_xfer_data;
   logic [1:0][7:0]                o_rvalid;
   int                             mismatches, comparisons, seed;
   logic [3:0]                     ch;
   logic [1:0][3:0]                o_chan;
   logic [9:0]                     prev_lvl;
   logic [3:0]                     q[$];
   dasc_top dut (.i_ref_clk, .i_rstn, .i_sync, .i_fast, .i_stc, .i_ctc, .i_apd, .i_fifo_en,
      .i_wfr, .i_reduce, .i_lim_lo, .i_lim_hi, .i_acc_cnt, .i_irq_en, .i_xfer_en, .i_prio,
      .i_trig_sel, .i_bwd, .i_mux_test, .i_trig, .i_sw_start, .i_par_mask, .i_par_ext,
      .i_q_push, .i_q_req, .i_ins_req, .i_rd, .i_rd_idx, .i_xfer_ack, .i_cmp, .i_pin,
      .i_dig_dis, .o_dac, .o_chan, .o_ext_mux, .o_shared(), .o_sample(), .o_pre(),
      .o_mtest(), .o_pd, .o_busy, .o_q_full(), .o_rd_data, .o_rvalid, .o_xfer_req(),
      .o_xfer_idx(), .o_xfer_data, .o_srv_req(), .o_port_in);
   dasc_analog_src src (.i_dac(o_dac), .i_level(lvl), .o_cmp(i_cmp));
   initial
   begin
      i_ref_clk = 1'b0;
      forever #50 i_ref_clk = ~i_ref_clk;
   end
   task automatic end_of_test;
      if (mismatches == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         mismatches++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   // read is taken at one edge, data stands from the next
   task automatic rd_chk(input int c, input logic [2:0] idx, input logic [17:0] exp);
      @(negedge i_ref_clk);
      i_rd[c] = 1'b1;
      i_rd_idx[c] = idx;
      @(negedge i_ref_clk);
      i_rd[c] = 1'b0;
      chk({6'h00, o_rd_data[c]}, {6'h00, exp});
   endtask
   task automatic wait_valid(input int c, input logic [7:0] m);
      for (int n = 0; n < 400 && (o_rvalid[c] & m) !== m; n++)
         @(negedge i_ref_clk);
      chk({16'h0000, o_rvalid[c] & m}, {16'h0000, m});
   endtask
   initial
   begin
      {i_sync, i_fast, i_apd, i_mux_test, i_q_push, i_rd, i_xfer_en, i_xfer_ack} = '0;
      {i_stc, i_wfr, i_ctc, i_acc_cnt, i_lim_lo, i_lim_hi, i_irq_en, i_par_ext} = '0;
      {i_prio, i_trig_sel, i_bwd, i_par_mask, i_trig, i_sw_start, i_rd_idx} = '0;
      {i_q_req, i_ins_req, i_pin, i_dig_dis, lvl} = '0;
      i_reduce = {dasc_pkg::RED_NONE, dasc_pkg::RED_NONE};
      i_fifo_en = 2'b11;
      i_apd = 2'b01;
      i_xfer_en = 2'b11;
      i_mux_test = 2'b10;
      i_rstn = 1'b0;
      mismatches = 0;
      comparisons = 0;
      seed = 32'h4a5d565a;
      repeat (6) @(negedge i_ref_clk);
      i_rstn = 1'b1;
      i_pin = 24'($random(seed));
      i_dig_dis = 24'($random(seed));
      repeat (2) @(negedge i_ref_clk);
      chk(o_port_in, i_pin & ~i_dig_dis);
      chk({22'h000000, o_pd}, 24'h000001);
      lvl[0] = 10'($random(seed));
      i_bwd[0] = 16'($random(seed));
      i_stc[0] = 8'h01;
      i_par_mask[0] = 16'h8024;
      for (int k = 0; k < 16; k++)
         if (i_par_mask[0][k])
            q.push_back(k[3:0]);
      i_sw_start[0][0] = 1'b1;
      @(negedge i_ref_clk);
      i_sw_start[0][0] = 1'b0;
      wait_valid(0, 8'h07);
      for (int k = 0; k < 3; k++)
         rd_chk(0, k[2:0], {4'h0, lvl[0], q[k]});
      q.delete();
      lvl[1] = $random(seed);
      i_fast[1] = 1'b1;
      for (int k = 0; k < 3; k++)
      begin
         ch = {1'b0, 3'($random(seed))};
         q.push_back(ch);
         i_q_req[1] = '{ext: 2'h0, chan: ch};
         i_q_push[1] = 1'b1;
         @(negedge i_ref_clk);
      end
      i_q_push[1] = 1'b0;
      i_sw_start[1][1] = 1'b1;
      @(negedge i_ref_clk);
      i_sw_start[1][1] = 1'b0;
      wait_valid(1, 8'h07);
      for (int k = 0; k < 3; k++)
         rd_chk(1, k[2:0], {6'h00, lvl[1][9:2], q[k]});
      // synchronized inserts from an event edge, register chosen by channel
      i_sync = 1'b1;
      i_fifo_en = 2'b00;
      i_wfr = 16'hFFFF;
      i_trig_sel[0][2] = 3'h5;
      i_trig_sel[1][2] = 3'h5;
      i_ins_req[0] = '{ext: 2'h1, chan: 4'h1};
      i_ins_req[1] = '{ext: 2'h2, chan: 4'h3};
      lvl[0] = 10'($random(seed));
      lvl[1] = 10'($random(seed));
      @(negedge i_ref_clk);
      i_trig[5] = 1'b1;
      wait_valid(0, 8'h02);
      wait_valid(1, 8'h08);
      chk({12'h000, o_ext_mux[1], o_chan[1], o_ext_mux[0], o_chan[0]}, 24'h0008D1);
      chk({6'h00, o_xfer_data[0]}, {10'h000, lvl[0], 4'h1});
      // a second insert onto the unread protected register must wait for the read
      i_sync = 1'b0;
      prev_lvl = lvl[0];
      lvl[0] = 10'($random(seed));
      i_sw_start[0][2] = 1'b1;
      @(negedge i_ref_clk);
      i_sw_start[0][2] = 1'b0;
      repeat (20) @(negedge i_ref_clk);
      chk({22'h000000, o_busy}, 24'h000000);
      rd_chk(0, 3'h1, {4'h0, prev_lvl, 4'h1});
      wait_valid(0, 8'h02);
      rd_chk(0, 3'h1, {4'h0, lvl[0], 4'h1});
      rd_chk(1, 3'h3, {6'h00, lvl[1][9:2], 4'h3});
      end_of_test;
   end
   initial
   begin
      #2000000;
      mismatches++;
      end_of_test;
   end
endmodule
`default_nettype wire
